/* File: pkg/igs_pkg.sv */
// Shared constants for the indicator / general I/O pin mux with reset straps
package igs_pkg;

  // Wishbone data width and the byte-address bits that the slave decodes
  localparam int unsigned IGS_DW = 32;
  localparam int unsigned IGS_AW = 5;

  // Register byte offsets
  localparam logic [IGS_AW-1:0] IGS_OFF_IND_CFG   = 5'h00; // Indicator config
  localparam logic [IGS_AW-1:0] IGS_OFF_IO_CFG    = 5'h04; // Driver type in general mode
  localparam logic [IGS_AW-1:0] IGS_OFF_DATA_DIR  = 5'h08; // Data, direction, pin levels
  localparam logic [IGS_AW-1:0] IGS_OFF_STRAP     = 5'h0C; // Latched straps, read only
  localparam logic [IGS_AW-1:0] IGS_OFF_PHY_ADDR  = 5'h10; // Management addresses

  // Indicator config fields
  localparam int unsigned IGS_IND4_EN_BIT = 0;
  localparam int unsigned IGS_IND5_EN_BIT = 1;
  localparam int unsigned IGS_FUN_LSB     = 8;

  // General I/O config and data/direction fields
  localparam int unsigned IGS_OD4_BIT   = 0;
  localparam int unsigned IGS_OD5_BIT   = 1;
  localparam int unsigned IGS_DATA4_BIT = 0;
  localparam int unsigned IGS_DATA5_BIT = 1;
  localparam int unsigned IGS_DIR4_BIT  = 8;
  localparam int unsigned IGS_DIR5_BIT  = 9;
  localparam int unsigned IGS_LVL4_BIT  = 16;
  localparam int unsigned IGS_LVL5_BIT  = 17;

  // Strap status fields
  localparam int unsigned IGS_STRAP5_BIT  = 0;
  localparam int unsigned IGS_STRAP4_BIT  = 1;
  localparam int unsigned IGS_LATCHED_BIT = 2;

  // Management address fields
  localparam int unsigned IGS_MA_W     = 5;
  localparam int unsigned IGS_VPHY_LSB = 0;
  localparam int unsigned IGS_P1_LSB   = 8;
  localparam int unsigned IGS_P2_LSB   = 16;

  // Writable bit masks
  localparam logic [IGS_DW-1:0] IGS_IND_CFG_MASK  = 32'h0000_0303;
  localparam logic [IGS_DW-1:0] IGS_IO_CFG_MASK   = 32'h0000_0003;
  localparam logic [IGS_DW-1:0] IGS_DATA_DIR_MASK = 32'h0000_0303;
  localparam logic [IGS_DW-1:0] IGS_PHY_ADDR_MASK = 32'h001F_1F1F;

  // Values after reset
  localparam logic [IGS_DW-1:0] IGS_IND_CFG_RST  = 32'h0000_0000;
  localparam logic [IGS_DW-1:0] IGS_IO_CFG_RST   = 32'h0000_0000;
  localparam logic [IGS_DW-1:0] IGS_DATA_DIR_RST = 32'h0000_0000;
  localparam logic [IGS_DW-1:0] IGS_PHY_ADDR_RST = 32'h0000_0000;

  // Management address defaults with the strap at 0; a strap of 1 adds one
  localparam logic [IGS_MA_W-1:0] IGS_VPHY_BASE = 5'h00;
  localparam logic [IGS_MA_W-1:0] IGS_P1_BASE   = 5'h01;
  localparam logic [IGS_MA_W-1:0] IGS_P2_BASE   = 5'h02;

  // Strap capture sequence
  typedef enum logic [1:0] {IGS_ST_SAMPLE, IGS_ST_LOAD, IGS_ST_HOLD} igs_strap_st_t;

  // Function field values with the high bit set select the open drive
  function automatic logic igs_open_drive(input logic [1:0] fun);
    return fun[1];
  endfunction : igs_open_drive

  // Byte-lane write merge limited to the implemented bits
  function automatic logic [IGS_DW-1:0] igs_merge(input logic [IGS_DW-1:0] old,
                                                  input logic [IGS_DW-1:0] wdat,
                                                  input logic [3:0]        sel,
                                                  input logic [IGS_DW-1:0] mask);
    logic [IGS_DW-1:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    return (res & mask) | (old & ~mask);
  endfunction : igs_merge

endpackage : igs_pkg

/* File: verilog/igs_strap_latch.sv */
`timescale 1ns/1ps
`default_nettype none
// Catches both strap pins while reset is held and freezes them at release
module igs_strap_latch
  import igs_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin levels
  input  wire logic pin_five_i,
  input  wire logic pin_four_i,
  // Latched values
  output logic      strap_five_o,
  output logic      strap_four_o,
  output logic      load_pulse_o,
  output logic      latched_o
);

  igs_strap_st_t st_q, st_d;  // Capture sequence
  logic          pulse_d;     // Next load pulse

  // Pulse once in the first cycle after release, then hold forever
  always_comb begin
    unique case (st_q)
      IGS_ST_SAMPLE: st_d = IGS_ST_LOAD;
      IGS_ST_LOAD:   st_d = IGS_ST_HOLD;
      IGS_ST_HOLD:   st_d = IGS_ST_HOLD;
    endcase
    pulse_d = (st_q == IGS_ST_SAMPLE);
  end

  // Pins are not driven during reset, so the board pull decides their level;
  // the value seen at the last reset edge is the one kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q         <= IGS_ST_SAMPLE;
      strap_five_o <= pin_five_i;
      strap_four_o <= pin_four_i;
      load_pulse_o <= 1'b0;
      latched_o    <= 1'b0;
    end else begin
      st_q         <= st_d;
      load_pulse_o <= pulse_d;
      latched_o    <= 1'b1;
    end
  end

endmodule : igs_strap_latch
`default_nettype wire

/* File: verilog/igs_pad_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
// Drive logic for one shared pin, registered so the pad sees clean levels
module igs_pad_ctl (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Indicator side
  input  wire logic ind_en_i,      // Pin works as indicator
  input  wire logic ind_on_i,      // Indicator lit
  input  wire logic ind_open_i,    // Open drive selected
  input  wire logic ind_act_low_i, // Latched strap polarity
  // General I/O side
  input  wire logic io_open_i,     // Open-drain output
  input  wire logic io_out_i,      // Direction is output
  input  wire logic io_data_i,     // Output data
  // Pad
  output logic      pad_o,
  output logic      pad_oe_o
);

  logic pad_d;  // Next pad level
  logic oe_d;   // Next pad enable

  // Select the driver form for the current mode
  always_comb begin
    pad_d = 1'b0;
    oe_d  = 1'b0;
    if (ind_en_i) begin
      if (!ind_open_i) begin
        // Push-pull indicator, lit drives high
        pad_d = ind_on_i;
        oe_d  = 1'b1;
      end else if (ind_act_low_i) begin
        // Strap 1: sinks current to light a lamp tied to supply
        pad_d = 1'b0;
        oe_d  = ind_on_i;
      end else begin
        // Strap 0: sources current into a lamp tied to ground
        pad_d = 1'b1;
        oe_d  = ind_on_i;
      end
    end else if (io_out_i) begin
      // Open drain only ever pulls low; a 1 releases the pin
      pad_d = io_open_i ? 1'b0 : io_data_i;
      oe_d  = io_open_i ? !io_data_i : 1'b1;
    end
  end

  // Pins stay released through reset so straps read the board pulls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_o    <= 1'b0;
      pad_oe_o <= 1'b0;
    end else begin
      pad_o    <= pad_d;
      pad_oe_o <= oe_d;
    end
  end

endmodule : igs_pad_ctl
`default_nettype wire

/* File: verilog/igs_pin_mux.sv */
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Pin five enabled: drive as indicator
// - Pin five disabled: acts as general I/O
// - Pin four enable selects indicator or I/O
// - Function field picks push-pull or open drive
// - Open drive takes polarity from reset strap
// - Strap 0 means indicator active high
// - Strap 1 means indicator active low
// - Strap five sets default management addresses
// - Strap 0: addresses 0, 1, 2
// - Strap 1: addresses 1, 2, 3
// - General mode: push-pull, open-drain or input
// - Strap four gives management mode bit one
// - Straps latch at reset release; software may override the default addresses only
module igs_pin_mux
  import igs_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [IGS_AW-1:0]    wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [IGS_DW-1:0]    wb_dat_i,
  output logic      [IGS_DW-1:0]    wb_dat_o,
  output logic                      wb_ack_o,
  // Indicator event sources, high means lit
  input  wire logic                 ind_on_five_i,
  input  wire logic                 ind_on_four_i,
  // Shared pin five
  input  wire logic                 indicator_pin_five_i,
  output logic                      indicator_pin_five_o,
  output logic                      indicator_pin_five_oe_o,
  // Shared pin four
  input  wire logic                 indicator_pin_four_i,
  output logic                      indicator_pin_four_o,
  output logic                      indicator_pin_four_oe_o,
  // Strap results for the rest of the switch
  output logic                      mgmt_mode_hi_o,
  output logic      [IGS_MA_W-1:0]  vphy_addr_o,
  output logic      [IGS_MA_W-1:0]  port_one_addr_o,
  output logic      [IGS_MA_W-1:0]  port_two_addr_o
);

  // Registers
  logic [IGS_DW-1:0]   ind_cfg_q,  ind_cfg_d;   // Enables and function field
  logic [IGS_DW-1:0]   io_cfg_q,   io_cfg_d;    // Open-drain selects
  logic [IGS_DW-1:0]   data_dir_q, data_dir_d;  // Output data and direction
  logic [IGS_DW-1:0]   phy_addr_q, phy_addr_d;  // Management addresses

  // Bus response state
  logic                ack_d;     // Next acknowledge
  logic [IGS_DW-1:0]   rdat_d;    // Next read data
  logic                wr_take;   // Write accepted this cycle

  // Strap results
  logic                strap_five;   // Address and polarity strap five
  logic                strap_four;   // Mode bit and polarity strap four
  logic                strap_load;   // One-cycle pulse after release
  logic                strap_done;   // Straps frozen

  // Decoded controls
  logic                open_drive;   // Indicator uses open drive
  logic [IGS_MA_W-1:0] strap_add;    // Address offset from strap five

  // Strap capture; strap four also feeds the management mode select
  igs_strap_latch u_straps (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .pin_five_i   (indicator_pin_five_i),
    .pin_four_i   (indicator_pin_four_i),
    .strap_five_o (strap_five),
    .strap_four_o (strap_four),
    .load_pulse_o (strap_load),
    .latched_o    (strap_done)
  );

  // Mode bit one is the pin four strap itself
  assign mgmt_mode_hi_o = strap_four;

  // Driver type applies to both indicator pins alike
  always_comb begin
    open_drive = igs_open_drive(ind_cfg_q[IGS_FUN_LSB +: 2]);
  end

  // Pin five: indicator when enabled, general I/O otherwise
  igs_pad_ctl u_pad_five (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ind_en_i      (ind_cfg_q[IGS_IND5_EN_BIT]),
    .ind_on_i      (ind_on_five_i),
    .ind_open_i    (open_drive),
    .ind_act_low_i (strap_five),
    .io_open_i     (io_cfg_q[IGS_OD5_BIT]),
    .io_out_i      (data_dir_q[IGS_DIR5_BIT]),
    .io_data_i     (data_dir_q[IGS_DATA5_BIT]),
    .pad_o         (indicator_pin_five_o),
    .pad_oe_o      (indicator_pin_five_oe_o)
  );

  // Pin four: same structure, its own enable and strap
  igs_pad_ctl u_pad_four (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ind_en_i      (ind_cfg_q[IGS_IND4_EN_BIT]),
    .ind_on_i      (ind_on_four_i),
    .ind_open_i    (open_drive),
    .ind_act_low_i (strap_four),
    .io_open_i     (io_cfg_q[IGS_OD4_BIT]),
    .io_out_i      (data_dir_q[IGS_DIR4_BIT]),
    .io_data_i     (data_dir_q[IGS_DATA4_BIT]),
    .pad_o         (indicator_pin_four_o),
    .pad_oe_o      (indicator_pin_four_oe_o)
  );

  // Address offset of one when strap five is high
  always_comb begin
    strap_add = {{(IGS_MA_W-1){1'b0}}, strap_five};
  end

  // Bus: answer every request one cycle after it is seen, then drop ack
  // so the master can release; unmapped offsets read zero and ignore writes
  always_comb begin
    ack_d   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr_take = ack_d && wb_we_i;
    rdat_d  = '0;
    if (ack_d && !wb_we_i) begin
      unique case (wb_adr_i)
        IGS_OFF_IND_CFG:  begin
          rdat_d = ind_cfg_q;
        end
        IGS_OFF_IO_CFG:   begin
          rdat_d = io_cfg_q;
        end
        IGS_OFF_DATA_DIR: begin
          // Input levels read back whatever the direction, as a Schmitt input
          rdat_d = data_dir_q;
          rdat_d[IGS_LVL4_BIT] = indicator_pin_four_i;
          rdat_d[IGS_LVL5_BIT] = indicator_pin_five_i;
        end
        IGS_OFF_STRAP:    begin
          rdat_d[IGS_STRAP5_BIT]  = strap_five;
          rdat_d[IGS_STRAP4_BIT]  = strap_four;
          rdat_d[IGS_LATCHED_BIT] = strap_done;
        end
        IGS_OFF_PHY_ADDR: begin
          rdat_d = phy_addr_q;
        end
        default:          begin
          rdat_d = '0;
        end
      endcase
    end
  end

  // Bus response registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= ack_d;
      wb_dat_o <= rdat_d;
    end
  end

  // Register writes take effect at the edge that raises ack
  always_comb begin
    ind_cfg_d  = ind_cfg_q;
    io_cfg_d   = io_cfg_q;
    data_dir_d = data_dir_q;
    phy_addr_d = phy_addr_q;
    // Address defaults come from the strap once it is frozen
    if (strap_load) begin
      phy_addr_d = '0;
      phy_addr_d[IGS_VPHY_LSB +: IGS_MA_W] = IGS_VPHY_BASE + strap_add;
      phy_addr_d[IGS_P1_LSB +: IGS_MA_W]   = IGS_P1_BASE + strap_add;
      phy_addr_d[IGS_P2_LSB +: IGS_MA_W]   = IGS_P2_BASE + strap_add;
    end
    if (wr_take) begin
      unique case (wb_adr_i)
        IGS_OFF_IND_CFG:  begin
          ind_cfg_d = igs_merge(ind_cfg_q, wb_dat_i, wb_sel_i, IGS_IND_CFG_MASK);
        end
        IGS_OFF_IO_CFG:   begin
          io_cfg_d = igs_merge(io_cfg_q, wb_dat_i, wb_sel_i, IGS_IO_CFG_MASK);
        end
        IGS_OFF_DATA_DIR: begin
          data_dir_d = igs_merge(data_dir_q, wb_dat_i, wb_sel_i, IGS_DATA_DIR_MASK);
        end
        IGS_OFF_PHY_ADDR: begin
          // Software override of the strapped defaults
          phy_addr_d = igs_merge(phy_addr_d, wb_dat_i, wb_sel_i, IGS_PHY_ADDR_MASK);
        end
        default:          begin
          // Strap status is read only; other offsets ignore writes
          ind_cfg_d = ind_cfg_q;
        end
      endcase
    end
  end

  // Configuration registers; pins start as general inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ind_cfg_q  <= IGS_IND_CFG_RST;
      io_cfg_q   <= IGS_IO_CFG_RST;
      data_dir_q <= IGS_DATA_DIR_RST;
      phy_addr_q <= IGS_PHY_ADDR_RST;
    end else begin
      ind_cfg_q  <= ind_cfg_d;
      io_cfg_q   <= io_cfg_d;
      data_dir_q <= data_dir_d;
      phy_addr_q <= phy_addr_d;
    end
  end

  // Address outputs, registered so they change one cycle after the register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vphy_addr_o     <= '0;
      port_one_addr_o <= '0;
      port_two_addr_o <= '0;
    end else begin
      vphy_addr_o     <= phy_addr_q[IGS_VPHY_LSB +: IGS_MA_W];
      port_one_addr_o <= phy_addr_q[IGS_P1_LSB +: IGS_MA_W];
      port_two_addr_o <= phy_addr_q[IGS_P2_LSB +: IGS_MA_W];
    end
  end

endmodule : igs_pin_mux
`default_nettype wire

/* File: tb/igs_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Board side of the two shared pins: strap resistors, pull-ups, outside drive
module igs_board_model (
  // Reset, straps and outside drive, bit 1 is pin five
  input  wire logic       rst_i,
  input  wire logic [1:0] strap_i,
  input  wire logic       ext_en_i,
  input  wire logic [1:0] ext_i,
  // Pads from the block
  input  wire logic       five_i, five_oe_i, four_i, four_oe_i,
  // Resolved levels
  output logic            pin_five_o,
  output logic            pin_four_o
);
  // Block driver wins; strap level during reset; then outside drive when enabled, else the pull-up
  always_comb begin
    pin_five_o = five_oe_i ? five_i : (rst_i ? strap_i[1] : (ext_en_i ? ext_i[1] : 1'b1));
    pin_four_o = four_oe_i ? four_i : (rst_i ? strap_i[0] : (ext_en_i ? ext_i[0] : 1'b1));
  end
endmodule : igs_board_model
`default_nettype wire

/* File: tb/igs_pin_mux_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// Port checker; shadows config writes so pad drive can be predicted
module igs_pin_mux_sva
  import igs_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [IGS_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [IGS_DW-1:0] wb_dat_i,
  // Pins and strap results
  input wire logic ind_on_five_i, ind_on_four_i,
  input wire logic indicator_pin_five_i, indicator_pin_four_i,
  input wire logic indicator_pin_five_o, indicator_pin_five_oe_o,
  input wire logic indicator_pin_four_o, indicator_pin_four_oe_o,
  input wire logic mgmt_mode_hi_o,
  input wire logic [IGS_MA_W-1:0] vphy_addr_o, port_one_addr_o, port_two_addr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0] en_q, od_q, d_q, dir_q, s_q; // Index 1 is pin five
  logic [1:0] on, e_oe, e_out, e_ck;       // Predicted pad drive
  logic       fun_q, wr;                   // Open drive flag, write taken
  assign on = {ind_on_five_i, ind_on_four_i};
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  // Shadow lands on the taken edge, like the block; straps track pins in reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {en_q, fun_q, od_q, d_q, dir_q} <= '0;
      s_q <= {indicator_pin_five_i, indicator_pin_four_i};
    end else if (wr) begin
      if (wb_adr_i == IGS_OFF_IND_CFG && wb_sel_i[0]) en_q <= wb_dat_i[1:0];
      if (wb_adr_i == IGS_OFF_IND_CFG && wb_sel_i[1]) fun_q <= wb_dat_i[IGS_FUN_LSB+1];
      if (wb_adr_i == IGS_OFF_IO_CFG && wb_sel_i[0]) od_q <= wb_dat_i[1:0];
      if (wb_adr_i == IGS_OFF_DATA_DIR && wb_sel_i[0]) d_q <= wb_dat_i[1:0];
      if (wb_adr_i == IGS_OFF_DATA_DIR && wb_sel_i[1]) dir_q <= wb_dat_i[9:8];
    end
  end
  // Out level is only checked where the pin is driven or held at a known level
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      e_oe[i] = en_q[i] ? (fun_q ? on[i] : 1'b1) : (dir_q[i] && !(od_q[i] && d_q[i]));
      e_out[i] = en_q[i] ? (fun_q ? !s_q[i] : on[i]) : (!od_q[i] && d_q[i]);
      e_ck[i] = en_q[i] || dir_q[i];
    end
  end
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_release;
    $fell(rst_i);
  endsequence
  a_pin5_ind: assert property (en_q[1] |=>
    indicator_pin_five_oe_o == $past(e_oe[1]) && indicator_pin_five_o == $past(e_out[1]))
    else $error("pin five indicator drive wrong");
  a_pin5_gpio: assert property (!en_q[1] |=> indicator_pin_five_oe_o == $past(e_oe[1])
    && (!$past(e_ck[1]) || indicator_pin_five_o == $past(e_out[1])))
    else $error("pin five general drive wrong");
  a_pin4_ind: assert property (en_q[0] |=>
    indicator_pin_four_oe_o == $past(e_oe[0]) && indicator_pin_four_o == $past(e_out[0]))
    else $error("pin four indicator drive wrong");
  a_pin4_gpio: assert property (!en_q[0] |=> indicator_pin_four_oe_o == $past(e_oe[0])
    && (!$past(e_ck[0]) || indicator_pin_four_o == $past(e_out[0])))
    else $error("pin four general drive wrong");
  a_addr_default: assert property (s_release |-> ##3 (vphy_addr_o == IGS_VPHY_BASE + 5'(s_q[1])
    && port_one_addr_o == IGS_P1_BASE + 5'(s_q[1]) && port_two_addr_o == IGS_P2_BASE + 5'(s_q[1])))
    else $error("default addresses wrong");
  a_mode_strap: assert property (!$past(rst_i) |-> mgmt_mode_hi_o == s_q[0])
    else $error("mode bit differs from strap four");
  a_strap_frozen: assert property (!$past(rst_i) |-> $stable(mgmt_mode_hi_o))
    else $error("mode bit moved outside reset");
  a_ack_pulse: assert property (s_taken |=> s_ack_pulse)
    else $error("ack not a one cycle answer");
endmodule : igs_pin_mux_sva
bind igs_pin_mux igs_pin_mux_sva igs_pin_mux_sva_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_sel_i, .wb_dat_i, .ind_on_five_i, .ind_on_four_i,
  .indicator_pin_five_i, .indicator_pin_four_i, .indicator_pin_five_o, .indicator_pin_five_oe_o,
  .indicator_pin_four_o, .indicator_pin_four_oe_o, .mgmt_mode_hi_o, .vphy_addr_o,
  .port_one_addr_o, .port_two_addr_o);
`default_nettype wire

/* File: tb/igs_pin_mux_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Bench: bus reads queue their expected word, a monitor compares at ack
module igs_pin_mux_tb_top;
  import igs_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o; // Clock, reset, bus
  logic [IGS_AW-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [IGS_DW-1:0] wb_dat_i, wb_dat_o, r;
  logic [1:0] on, strap, ext, od, d, dir, lv, drv;           // Index 1 is pin five
  logic ext_en, pin5, pin4, o5, oe5, o4, oe4, mgmt;
  logic [IGS_MA_W-1:0] vphy, p1, p2;
  logic [31:0] exp_q[$];                                     // Expected read words
  string what_q[$];
  int num_errors = 0;
  int checks = 0;
  igs_pin_mux igs_pin_mux_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ind_on_five_i(on[1]), .ind_on_four_i(on[0]),
    .indicator_pin_five_i(pin5), .indicator_pin_five_o(o5), .indicator_pin_five_oe_o(oe5),
    .indicator_pin_four_i(pin4), .indicator_pin_four_o(o4), .indicator_pin_four_oe_o(oe4),
    .mgmt_mode_hi_o(mgmt), .vphy_addr_o(vphy), .port_one_addr_o(p1), .port_two_addr_o(p2));
  igs_board_model igs_board_model_inst (.rst_i, .strap_i(strap), .ext_en_i(ext_en),
    .ext_i(ext), .five_i(o5), .five_oe_i(oe5), .four_i(o4), .four_oe_i(oe4),
    .pin_five_o(pin5), .pin_four_o(pin4));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] seen);
    checks++;
    if (seen !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, seen);
    end
  endtask : check
  // Classic single cycle; a read queues its expected word first
  task automatic wb_xfer(input logic we, input logic [IGS_AW-1:0] adr,
                         input logic [IGS_DW-1:0] dat, input string what);
    int n;
    n = 0;
    if (!we) begin
      exp_q.push_back(dat);
      what_q.push_back(what);
    end
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hF};
    wb_adr_i <= adr;
    wb_dat_i <= we ? dat : 32'h0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      close_out();
    end
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    @(posedge clk_i);
  endtask : wb_xfer
  // Straps are presented for the whole reset and released with it
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask : do_reset
  // Read data is only valid in the ack cycle, so compare there
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      check(what_q.pop_front(), exp_q.pop_front(), wb_dat_o);
    end
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, ext_en} = 5'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i, on, strap, ext} = '0;
    r = $urandom(32'h4657);
    for (int t = 0; t < 2; t++) begin
      strap <= t[0] ? 2'b10 : 2'b01;
      do_reset();
      check("mgmt_mode_hi_o", {31'h0, strap[0]}, {31'h0, mgmt});
      wb_xfer(1'b0, IGS_OFF_STRAP, {29'h0, 1'b1, strap[0], strap[1]}, "straps");
      wb_xfer(1'b1, IGS_OFF_STRAP, 32'hFFFF_FFFF, "");
      wb_xfer(1'b0, IGS_OFF_STRAP, {29'h0, 1'b1, strap[0], strap[1]}, "read-only straps");
      wb_xfer(1'b0, IGS_OFF_PHY_ADDR, {11'h0, IGS_P2_BASE + 5'(strap[1]), 3'h0,
        IGS_P1_BASE + 5'(strap[1]), 3'h0, IGS_VPHY_BASE + 5'(strap[1])}, "addresses");
      wb_xfer(1'b0, 5'h14, 32'h0, "unmapped");
      wb_xfer(1'b0, IGS_OFF_IND_CFG, IGS_IND_CFG_RST, "indicator config reset");
      // General I/O with random drive type, direction and board levels
      ext_en <= 1'b1;
      repeat (8) begin
        r = $urandom;
        {dir, d, od} = r[5:0];
        ext <= r[7:6];
        drv = dir & ~(od & d);
        lv = (drv & d) | (~drv & r[7:6]);
        wb_xfer(1'b1, IGS_OFF_IO_CFG, {30'h0, od}, "");
        wb_xfer(1'b1, IGS_OFF_DATA_DIR, {22'h0, dir, 6'h0, d}, "");
        repeat (4) @(posedge clk_i);
        wb_xfer(1'b0, IGS_OFF_DATA_DIR, {14'h0, lv, 6'h0, dir, 6'h0, d}, "gpio levels");
      end
      // Every function code with both pins as indicators, board released
      ext_en <= 1'b0;
      for (int f = 0; f < 4; f++) begin
        r = $urandom;
        on <= r[1:0];
        lv = f[1] ? ~(r[1:0] & strap) : r[1:0];
        wb_xfer(1'b1, IGS_OFF_IND_CFG, {22'h0, f[1:0], 8'h03}, "");
        repeat (4) @(posedge clk_i);
        wb_xfer(1'b0, IGS_OFF_DATA_DIR, {14'h0, lv, 6'h0, dir, 6'h0, d}, "indicator levels");
      end
      // Software override of the strap addresses
      r = $urandom & IGS_PHY_ADDR_MASK;
      wb_xfer(1'b1, IGS_OFF_PHY_ADDR, r, "");
      wb_xfer(1'b0, IGS_OFF_PHY_ADDR, r, "address override");
      // Address outputs trail the register by one cycle; the read above gives them time
      check("vphy_addr_o", {27'h0, r[4:0]}, {27'h0, vphy});
      check("port_one_addr_o", {27'h0, r[12:8]}, {27'h0, p1});
      check("port_two_addr_o", {27'h0, r[20:16]}, {27'h0, p2});
      $display("strap test %0d done", t);
    end
    close_out();
  end
endmodule : igs_pin_mux_tb_top
`default_nettype wire
